// ==== core/ser_defs.vh ====
`ifndef SER_DEFS_VH
`define SER_DEFS_VH

// ****************************************
// command selector codes
// ****************************************
`define SER_SEL_OPERATION_SUMMARY_COND    4'h0
`define SER_SEL_OPERATION_SUMMARY_EVENT   4'h1
`define SER_SEL_OPERATION_SUMMARY_ENABLE  4'h2
`define SER_SEL_QUESTIONABLE_SUMMARY_COND    4'h3
`define SER_SEL_QUESTIONABLE_SUMMARY_EVENT   4'h4
`define SER_SEL_QUESTIONABLE_SUMMARY_ENABLE  4'h5
`define SER_SEL_STD_EVENT    4'h6
`define SER_SEL_STD_ENABLE   4'h7
`define SER_SEL_STB          4'h8
`define SER_SEL_SRE          4'h9
`define SER_SEL_GRP_STRIDE   4'h3
`define SER_KIND_COND        2'h0
`define SER_KIND_EVENT       2'h1
`define SER_KIND_ENABLE      2'h2

// ****************************************
// group bit positions
// ****************************************
`define SER_OPERATION_SUMMARY_CALIBRATION_DONE  0
`define SER_OPERATION_SUMMARY_TRANSIENT_DONE    3
`define SER_OPERATION_SUMMARY_MEASUREMENT_DONE  4
`define SER_QUESTIONABLE_SUMMARY_OUTPUT_VOLTAGE    0
`define SER_QUESTIONABLE_SUMMARY_OVERCURRENT       1
`define SER_QUESTIONABLE_SUMMARY_OVERTEMPERATURE   3
`define SER_QUESTIONABLE_SUMMARY_REMOTE_SHUTDOWN   9
`define SER_QUESTIONABLE_SUMMARY_RMS_CURRENT_LIMIT 12
`define SER_OPERATION_SUMMARY_USED_MASK   16'h0019
`define SER_QUESTIONABLE_SUMMARY_USED_MASK   16'h120b

// ****************************************
// standard event bits
// ****************************************
`define SER_STD_OPC          0
`define SER_STD_QYE          2
`define SER_STD_DDE          3
`define SER_STD_EXE          4
`define SER_STD_CME          5
`define SER_STD_PON          7
`define SER_STD_USED_MASK    8'hbd
`define SER_STD_EVENT_RST    8'h80

// ****************************************
// status byte bits
// ****************************************
`define SER_STB_QUESTIONABLE_SUMMARY         3
`define SER_STB_MAV          4
`define SER_STB_ESB          5
`define SER_STB_RQS          6
`define SER_STB_OPERATION_SUMMARY         7

`define SER_ZERO16           16'h0000
`define SER_ZERO8            8'h00
`define SER_OQ_DEPTH         16
`define SER_OQ_ADDR_W        4

`endif

// ==== core/ser_status.v ====
// Notes on behaviour
// - condition registers mirror live circuit state and are read-only
// - event registers latch rising conditions, read-only, cleared by reading
// - enable registers are read/write masks selecting events into group summary
// - OR of enabled operation events drives status byte bit 7
// - operation bits: 0 calibration, 3 transient, 4 measurement done
// - questionable bits: 0 voltage, 1 overcurrent, 3 temp, 9 shutdown, 12 rms
// - OR of enabled questionable events drives status byte bit 3
// - standard event bit 7 set at power-up; bit 0 records operation complete, bits 2,3,4,5 record errors
// - standard enable masks standard events; OR drives status byte bit 5
// - enable write command; standard event read returns and clears it
// - status byte and service enable share layout bits 3,4,5,6,7
// - status byte query returns master summary in bit 6, clears nothing
// - master summary is unlatched OR of enabled status byte bits
// - service request asserts request line and latches request bit 6
// - serial poll returns latched request bit, then clears only it
// - output queue is a fifo; bit 4 set while it holds a byte
// - reading an event register also removes its summary contribution
// - all data and enable bits clear at power-up, except standard event bit 7
`timescale 1ns/1ps
`include "ser_defs.vh"

module ser_status #(
	parameter OQ_DEPTH  = `SER_OQ_DEPTH,
	parameter OQ_ADDR_W = `SER_OQ_ADDR_W
) (
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire [15:0] operation_summary_cond_in,
	input  wire [15:0] questionable_summary_cond_in,
	input  wire        opc_event,
	input  wire        query_error,
	input  wire        device_error,
	input  wire        execution_error,
	input  wire        command_error,
	input  wire [3:0]  cmd_sel,
	input  wire        cmd_rd,
	input  wire        cmd_wr,
	input  wire [15:0] cmd_wdata,
	output reg  [15:0] cmd_rdata,
	output reg         cmd_rvalid,
	input  wire        serial_poll,
	output reg  [7:0]  poll_data,
	output reg         poll_valid,
	output reg         srq_out,
	input  wire        oq_push,
	input  wire [7:0]  oq_wdata,
	output wire        oq_ready,
	input  wire        oq_pop,
	output reg  [7:0]  oq_rdata,
	output reg         oq_rvalid
);

	// ****************************************
	// selector decode
	// ****************************************
	function [3:0] grp_sel;
		input [1:0] g;
		input [1:0] k;
		begin
			grp_sel = `SER_SEL_OPERATION_SUMMARY_COND + (g * `SER_SEL_GRP_STRIDE) + {2'b00, k};
		end
	endfunction

	// ****************************************
	// condition synchronisers
	// ****************************************
	// circuits are asynchronous to core_clk, so each bit passes two flops
	// limitation: a condition pulse shorter than one clock may never be seen
	reg  [31:0] cond_meta_reg;
	reg  [31:0] cond_sync_reg;
	reg  [31:0] cond_prev_reg;
	wire [31:0] cond_used;
	wire [31:0] ev_all;
	wire [31:0] en_all;
	wire [1:0]  grp_sum;

	assign cond_used = {questionable_summary_cond_in & `SER_QUESTIONABLE_SUMMARY_USED_MASK,
		operation_summary_cond_in & `SER_OPERATION_SUMMARY_USED_MASK};

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cond_meta_reg <= {`SER_ZERO16, `SER_ZERO16};
			cond_sync_reg <= {`SER_ZERO16, `SER_ZERO16};
			cond_prev_reg <= {`SER_ZERO16, `SER_ZERO16};
		end else begin
			cond_meta_reg <= cond_used;
			cond_sync_reg <= cond_meta_reg;
			cond_prev_reg <= cond_sync_reg;
		end
	end

	// ****************************************
	// operation and questionable groups
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : grp
			reg  [15:0] event_reg;
			reg  [15:0] enable_reg;
			wire [15:0] set_bits;
			wire        rd_event;
			wire        wr_enable;

			// unused bits are masked before the flops, so they never rise here
			assign set_bits  = cond_sync_reg[16*g +: 16] & ~cond_prev_reg[16*g +: 16];
			assign rd_event  = cmd_rd &&
				(cmd_sel == grp_sel((g == 0) ? 2'h0 : 2'h1, `SER_KIND_EVENT));
			assign wr_enable = cmd_wr &&
				(cmd_sel == grp_sel((g == 0) ? 2'h0 : 2'h1, `SER_KIND_ENABLE));

			always @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					event_reg  <= `SER_ZERO16;
					enable_reg <= `SER_ZERO16;
				end else begin
					// set beats the clearing read so nothing is dropped
					event_reg <= (rd_event ? `SER_ZERO16 : event_reg) | set_bits;
					if (wr_enable) begin
						enable_reg <= cmd_wdata;
					end
				end
			end

			assign ev_all[16*g +: 16] = event_reg;
			assign en_all[16*g +: 16] = enable_reg;
			// cleared events drop out of the summary on the next cycle
			assign grp_sum[g] = |(event_reg & enable_reg);
		end
	endgenerate

	// ****************************************
	// standard event group
	// ****************************************
	reg  [7:0] std_event_reg;
	reg  [7:0] std_enable_reg;
	reg  [7:0] sre_reg;
	reg  [7:0] std_set;
	wire       std_rd;
	wire       esb;
	wire       wr_std_enable;
	wire       wr_sre;

	always @* begin
		std_set                   = `SER_ZERO8;
		std_set[`SER_STD_OPC]     = opc_event;
		std_set[`SER_STD_QYE]     = query_error;
		std_set[`SER_STD_DDE]     = device_error;
		std_set[`SER_STD_EXE]     = execution_error;
		std_set[`SER_STD_CME]     = command_error;
	end

	// ****************************************
	// write decode
	// ****************************************
	assign wr_std_enable = cmd_wr && (cmd_sel == `SER_SEL_STD_ENABLE);
	assign wr_sre        = cmd_wr && (cmd_sel == `SER_SEL_SRE);

	assign std_rd = cmd_rd && (cmd_sel == `SER_SEL_STD_EVENT);
	assign esb    = |(std_event_reg & std_enable_reg);

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			std_event_reg  <= `SER_STD_EVENT_RST;
			std_enable_reg <= `SER_ZERO8;
			sre_reg        <= `SER_ZERO8;
		end else begin
			std_event_reg <= (std_rd ? `SER_ZERO8 : std_event_reg) | std_set;
			if (wr_std_enable) begin
				std_enable_reg <= cmd_wdata[7:0] & `SER_STD_USED_MASK;
			end
			if (wr_sre) begin
				sre_reg <= cmd_wdata[7:0];
			end
		end
	end

	// ****************************************
	// output queue
	// ****************************************
	reg  [7:0]         oq_mem [0:OQ_DEPTH-1];
	reg  [OQ_ADDR_W-1:0] oq_wptr_reg;
	reg  [OQ_ADDR_W-1:0] oq_rptr_reg;
	reg  [OQ_ADDR_W:0]   oq_count_reg;
	// pointers wrap freely, so the depth must be a power of two
	wire               oq_empty;
	wire               oq_full;
	wire               oq_do_push;
	wire               oq_do_pop;
	wire               mav;

	assign oq_empty   = (oq_count_reg == {(OQ_ADDR_W+1){1'b0}});
	assign oq_full    = (oq_count_reg == OQ_DEPTH[OQ_ADDR_W:0]);
	assign oq_ready   = !oq_full;
	assign oq_do_push = oq_push && oq_ready;
	assign oq_do_pop  = oq_pop && !oq_empty;
	assign mav        = !oq_empty;

	always @(posedge core_clk) begin
		if (oq_do_push) begin
			oq_mem[oq_wptr_reg] <= oq_wdata;
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oq_wptr_reg  <= {OQ_ADDR_W{1'b0}};
			oq_rptr_reg  <= {OQ_ADDR_W{1'b0}};
			oq_count_reg <= {(OQ_ADDR_W+1){1'b0}};
			oq_rdata     <= `SER_ZERO8;
			oq_rvalid    <= 1'b0;
		end else begin
			oq_rvalid <= oq_do_pop;
			if (oq_do_push) begin
				oq_wptr_reg <= oq_wptr_reg + 1'b1;
			end
			if (oq_do_pop) begin
				oq_rdata    <= oq_mem[oq_rptr_reg];
				oq_rptr_reg <= oq_rptr_reg + 1'b1;
			end
			if (oq_do_push && !oq_do_pop) begin
				oq_count_reg <= oq_count_reg + 1'b1;
			end else if (oq_do_pop && !oq_do_push) begin
				oq_count_reg <= oq_count_reg - 1'b1;
			end
		end
	end

	// ****************************************
	// status byte and service request
	// ****************************************
	reg  [7:0] stb_base;
	reg        mss_prev_reg;
	reg        rqs_reg;
	wire       mss;
	wire       rqs_rise;
	wire       rqs_next;

	always @* begin
		stb_base                = `SER_ZERO8;
		stb_base[`SER_STB_QUESTIONABLE_SUMMARY] = grp_sum[1];
		stb_base[`SER_STB_MAV]  = mav;
		stb_base[`SER_STB_ESB]  = esb;
		stb_base[`SER_STB_OPERATION_SUMMARY] = grp_sum[0];
	end

	// bit 6 of the enable is ignored: the summary cannot feed itself
	assign mss      = |(stb_base & sre_reg);
	assign rqs_rise = mss && !mss_prev_reg;
	// a new request in the poll cycle survives the poll clear
	assign rqs_next = (rqs_reg && !serial_poll) || rqs_rise;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mss_prev_reg <= 1'b0;
			rqs_reg      <= 1'b0;
			srq_out      <= 1'b0;
			poll_data    <= `SER_ZERO8;
			poll_valid   <= 1'b0;
		end else begin
			mss_prev_reg <= mss;
			rqs_reg    <= rqs_next;
			srq_out    <= rqs_next;
			poll_valid <= serial_poll;
			if (serial_poll) begin
				poll_data <= stb_base | {1'b0, rqs_reg, 6'b000000};
			end
		end
	end

	// ****************************************
	// command read path
	// ****************************************
	reg [15:0] rd_mux;

	always @* begin
		case (cmd_sel)
			`SER_SEL_OPERATION_SUMMARY_COND:   rd_mux = cond_sync_reg[15:0];
			`SER_SEL_OPERATION_SUMMARY_EVENT:  rd_mux = ev_all[15:0];
			`SER_SEL_OPERATION_SUMMARY_ENABLE: rd_mux = en_all[15:0];
			`SER_SEL_QUESTIONABLE_SUMMARY_COND:   rd_mux = cond_sync_reg[31:16];
			`SER_SEL_QUESTIONABLE_SUMMARY_EVENT:  rd_mux = ev_all[31:16];
			`SER_SEL_QUESTIONABLE_SUMMARY_ENABLE: rd_mux = en_all[31:16];
			`SER_SEL_STD_EVENT:   rd_mux = {`SER_ZERO8, std_event_reg};
			`SER_SEL_STD_ENABLE:  rd_mux = {`SER_ZERO8, std_enable_reg};
			`SER_SEL_STB:         rd_mux = {`SER_ZERO8, stb_base | {1'b0, mss, 6'b000000}};
			`SER_SEL_SRE:         rd_mux = {`SER_ZERO8, sre_reg};
			default:              rd_mux = `SER_ZERO16;
		endcase
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata  <= `SER_ZERO16;
			cmd_rvalid <= 1'b0;
		end else begin
			cmd_rvalid <= cmd_rd;
			if (cmd_rd) begin
				cmd_rdata <= rd_mux;
			end
		end
	end

endmodule // ser_status

// ==== tb/ser_status_sva.sv ====
`timescale 1ns/1ps
module ser_status_sva (
	input wire        core_clk,
	input wire        reset_n,
	input wire [3:0]  cmd_sel,
	input wire        cmd_rd,
	input wire        cmd_wr,
	input wire [15:0] cmd_rdata,
	input wire        cmd_rvalid,
	input wire        serial_poll,
	input wire [7:0]  poll_data,
	input wire        poll_valid,
	input wire        srq_out,
	input wire        oq_pop,
	input wire        oq_rvalid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ********
	// checks
	// ********
	AST_POLL_ANS: assert property (serial_poll |=> poll_valid && poll_data[6] == $past(srq_out))
		else $error("poll answer wrong");
	// a fresh summary rise in the poll cycle could keep the line up; the bench never makes one
	AST_POLL_CLR: assert property (serial_poll && srq_out |=> !srq_out)
		else $error("request line kept after poll");
	AST_SRQ_HOLD: assert property (srq_out && !serial_poll |=> srq_out)
		else $error("request line dropped without poll");
	AST_RD_ANS: assert property (cmd_rd |=> cmd_rvalid)
		else $error("read not answered");
	AST_WR_QUIET: assert property (cmd_wr && !cmd_rd |=> !cmd_rvalid)
		else $error("write answered");
	AST_OPERATION_SUMMARY_BITS: assert property (cmd_rvalid && $past(cmd_sel) inside {4'h0, 4'h1}
		|-> (cmd_rdata & 16'hffe6) == 16'h0000)
		else $error("unused operation bit set");
	AST_QUESTIONABLE_SUMMARY_BITS: assert property (cmd_rvalid && $past(cmd_sel) inside {4'h3, 4'h4}
		|-> (cmd_rdata & 16'hedf4) == 16'h0000)
		else $error("unused questionable bit set");
	AST_BYTE_UPPER: assert property (cmd_rvalid && $past(cmd_sel) >= 4'h6
		|-> cmd_rdata[15:8] == 8'h00)
		else $error("byte register upper half set");
	AST_POP_ANS: assert property (oq_rvalid |-> $past(oq_pop))
		else $error("queue data without pop");
	cover property (serial_poll && srq_out);
	cover property (cmd_rvalid && cmd_rdata != 16'h0000);
	cover property (oq_rvalid);
endmodule // ser_status_sva

// ==== tb/ser_ctrl_model.sv ====
`timescale 1ns/1ps
module ser_ctrl_model (
	input  wire        core_clk,
	output logic [3:0]  cmd_sel,
	output logic        cmd_rd,
	output logic        cmd_wr,
	output logic [15:0] cmd_wdata,
	output logic        serial_poll,
	output logic        oq_pop,
	input  wire        cmd_rvalid,
	input  wire [15:0] cmd_rdata,
	input  wire        poll_valid,
	input  wire [7:0]  poll_data,
	input  wire        oq_rvalid,
	input  wire [7:0]  oq_rdata
);
	initial begin
		{cmd_sel, cmd_rd, cmd_wr, cmd_wdata, serial_poll, oq_pop} = '0;
	end
	// kind 0 read, 1 write, 2 serial poll, 3 queue pop; every answer lands one cycle after take
	task automatic op(input logic [1:0] k, input logic [3:0] s, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(posedge core_clk);
		cmd_sel <= s;
		cmd_wdata <= d;
		{oq_pop, serial_poll, cmd_wr, cmd_rd} <= 4'h1 << k;
		@(posedge core_clk);
		{oq_pop, serial_poll, cmd_wr, cmd_rd} <= 4'h0;
		#1;
		v = k[1] ? (k[0] ? oq_rvalid : poll_valid) : (k[0] ? !cmd_rvalid : cmd_rvalid);
		q = k[1] ? {8'h00, k[0] ? oq_rdata : poll_data} : cmd_rdata;
	endtask
endmodule // ser_ctrl_model

// ==== tb/test_ser_status.sv ====
`timescale 1ns/1ps
`include "ser_defs.vh"
module test_ser_status;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] operation_summary_cond_in = 16'h0000;
	logic [15:0] questionable_summary_cond_in = 16'h0000;
	logic [4:0]  err = 5'h00;
	logic        oq_push = 1'b0;
	logic [7:0]  oq_wdata = 8'h00;
	logic [3:0]  cmd_sel;
	logic        cmd_rd, cmd_wr, serial_poll, oq_pop, cmd_rvalid, poll_valid, srq_out, oq_rvalid;
	logic [15:0] cmd_wdata, cmd_rdata;
	logic [7:0]  poll_data, oq_rdata;
	logic        oq_ready;
	int          miscompares = 0;
	int          compares = 0;
	always #5 core_clk = ~core_clk;
	ser_status ser_status_i (.opc_event(err[0]), .query_error(err[1]), .device_error(err[2]),
		.execution_error(err[3]), .command_error(err[4]), .oq_ready(oq_ready), .*);
	ser_ctrl_model ser_ctrl_model_i (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one controller access; write data doubles as the expected read value
	task automatic acc(input logic [1:0] k, input logic [3:0] s, input logic [15:0] e);
		logic [15:0] q;
		logic        v;
		ser_ctrl_model_i.op(k, s, e, q, v);
		chk({15'h0000, v}, 16'h0001);
		if (k != 2'h1)
			chk(q, e);
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_reset;
		acc(0, `SER_SEL_STD_EVENT, 16'h0080);
		for (int s = 0; s < 16; s++)
			acc(0, s[3:0], 16'h0000);
	endtask
	task automatic t_operation_summary;
		acc(1, `SER_SEL_OPERATION_SUMMARY_ENABLE, 16'h0018);
		acc(0, `SER_SEL_OPERATION_SUMMARY_ENABLE, 16'h0018);
		@(posedge core_clk);
		operation_summary_cond_in <= 16'hffff;
		repeat (8) @(posedge core_clk);
		acc(1, `SER_SEL_OPERATION_SUMMARY_COND, 16'h0000);
		acc(0, `SER_SEL_OPERATION_SUMMARY_COND, 16'h0019);
		acc(0, `SER_SEL_STB, 16'h0080);
		acc(0, `SER_SEL_OPERATION_SUMMARY_EVENT, 16'h0019);
		acc(0, `SER_SEL_STB, 16'h0000);
		acc(0, `SER_SEL_OPERATION_SUMMARY_EVENT, 16'h0000);
	endtask
	task automatic t_questionable_summary;
		acc(1, `SER_SEL_QUESTIONABLE_SUMMARY_ENABLE, 16'h0008);
		acc(1, `SER_SEL_SRE, 16'h0008);
		@(posedge core_clk);
		questionable_summary_cond_in <= 16'h5002;
		repeat (8) @(posedge core_clk);
		acc(0, `SER_SEL_STB, 16'h0000);
		chk({15'h0000, srq_out}, 16'h0000);
		@(posedge core_clk);
		questionable_summary_cond_in <= 16'hffff;
		repeat (8) @(posedge core_clk);
		acc(0, `SER_SEL_QUESTIONABLE_SUMMARY_COND, 16'h120b);
		acc(0, `SER_SEL_STB, 16'h0048);
		chk({15'h0000, srq_out}, 16'h0001);
		// poll first, then the event register of the active summary
		acc(2, 4'h0, 16'h0048);
		acc(2, 4'h0, 16'h0008);
		chk({15'h0000, srq_out}, 16'h0000);
		acc(0, `SER_SEL_STB, 16'h0048);
		acc(1, `SER_SEL_SRE, 16'h0000);
		acc(0, `SER_SEL_STB, 16'h0008);
		chk({15'h0000, srq_out}, 16'h0000);
		acc(0, `SER_SEL_QUESTIONABLE_SUMMARY_EVENT, 16'h120b);
		acc(0, `SER_SEL_STB, 16'h0000);
	endtask
	task automatic t_std;
		acc(1, `SER_SEL_STD_ENABLE, 16'h00ff);
		acc(0, `SER_SEL_STD_ENABLE, 16'h00bd);
		@(posedge core_clk);
		err <= 5'h1f;
		@(posedge core_clk);
		err <= 5'h00;
		repeat (3) @(posedge core_clk);
		acc(0, `SER_SEL_STB, 16'h0020);
		acc(0, `SER_SEL_STD_EVENT, 16'h003d);
		acc(0, `SER_SEL_STD_EVENT, 16'h0000);
		// an event taken on the same edge as the clearing read must survive it
		fork
			acc(0, `SER_SEL_STD_EVENT, 16'h0000);
			begin
				@(posedge core_clk);
				err <= 5'h01;
				@(posedge core_clk);
				err <= 5'h00;
			end
		join
		acc(0, `SER_SEL_STD_EVENT, 16'h0001);
		acc(0, `SER_SEL_STB, 16'h0000);
	endtask
	task automatic t_queue;
		@(posedge core_clk);
		oq_push <= 1'b1;
		oq_wdata <= 8'h5a;
		@(posedge core_clk);
		oq_wdata <= 8'ha5;
		@(posedge core_clk);
		oq_push <= 1'b0;
		acc(0, `SER_SEL_STB, 16'h0010);
		acc(3, 4'h0, 16'h005a);
		acc(3, 4'h0, 16'h00a5);
		chk({15'h0000, oq_ready}, 16'h0001);
		@(posedge core_clk);
		oq_push <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			oq_wdata <= 8'h10 + i[7:0];
			@(posedge core_clk);
		end
		oq_push <= 1'b0;
		acc(0, `SER_SEL_STB, 16'h0010);
		chk({15'h0000, oq_ready}, 16'h0000);
		for (int i = 0; i < 16; i++)
			acc(3, 4'h0, 16'h0010 + i[15:0]);
		acc(0, `SER_SEL_STB, 16'h0000);
	endtask
	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// the whole sequence needs under two hundred cycles; this allows far more
	initial begin
		#100000;
		miscompares++;
		close_out;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset;
		t_operation_summary;
		t_questionable_summary;
		t_std;
		t_queue;
		close_out;
	end
endmodule // test_ser_status
bind ser_status ser_status_sva ser_status_sva_i (.*);
